// ### smrs_map.vh
// constants, register offsets and codes for the bus port and rate selection
// Summary of operation
// - bus address is captured once at power-up from four strap inputs.
// - seven-bit address is 0x18 plus strap value, 0x18 to 0x27.
// - address byte is eight bits; lsb 0 means write, 1 means read.
// - role select not low at power-up: ignore straps, answer write address 0x30.
// - after capture, registers are read and written over the two-wire bus.
// - data and clock lines are only pulled low or released, never driven high.
// - rate register upper nibble restricts coarse tuning set and divider ratios.
// - rate codes 0x26,0x36,0x46,0xa6,0xb6,0xc6 select fixed tuning and divider sets.
// - nibble 4'b1111 picks group and tuning automatically; dividers 8 and 1.
// - dividers switch among permitted ratios without further register writes.
// - frequency lock: measured count within tolerance of expected count.
// - two frequency groups, group 1 reached only in ethernet mode; ethernet: group 0 1.25G, group 1 10.3125G.
// - group 0 count at group0_count_low/group0_count_high, group 1 at group1_count_low/group1_count_high, tolerance count_tolerance.
// - high count register: seven low bits upper count, bit 7 manual load.
// - tolerance register holds two four-bit tolerances, one per group.
`ifndef SMRS_MAP_VH
`define SMRS_MAP_VH

// register offsets
`define SMRS_OFS_RATE 8'h2f
`define SMRS_OFS_G0_LO 8'h60
`define SMRS_OFS_G0_HI 8'h61
`define SMRS_OFS_G1_LO 8'h62
`define SMRS_OFS_G1_HI 8'h63
`define SMRS_OFS_TOL 8'h64
`define SMRS_REG_RESET 8'h00

// addressing
`define SMRS_ADDR_BASE 7'h18
`define SMRS_ADDR_TEST 7'h18
`define SMRS_CAP_WAIT 2'h3
`define SMRS_BITS_BYTE 4'h8

// rate nibble codes
`define SMRS_RATE_IB 4'h2
`define SMRS_RATE_CPRI1 4'h3
`define SMRS_RATE_CPRI2 4'h4
`define SMRS_RATE_PROP3 4'ha
`define SMRS_RATE_ILK1 4'hb
`define SMRS_RATE_ILK2 4'hc
`define SMRS_RATE_ETH 4'hf

// divider masks: bit0 /1, bit1 /2, bit2 /4, bit3 /8
`define SMRS_DIV_124 4'h7
`define SMRS_DIV_24 4'h6
`define SMRS_DIV_2 4'h2
`define SMRS_DIV_1 4'h1
`define SMRS_DIV_8 4'h8
`define SMRS_DIV_ANY 4'hf

// coarse tuning preset sets
`define SMRS_VCO_FREE 3'h0
`define SMRS_VCO_10G0 3'h1
`define SMRS_VCO_9G8304 3'h2
`define SMRS_VCO_12G288 3'h3
`define SMRS_VCO_12G5 3'h4
`define SMRS_VCO_10G3125 3'h5

// high count and tolerance register fields
`define SMRS_HI_MANUAL 7
`define SMRS_TOL_G0_LSB 0
`define SMRS_TOL_G1_LSB 4

`endif

// ### smrs_regfile.v
// register storage for rate and frequency-lock settings
`timescale 1ns/10ps
`default_nettype none
`include "smrs_map.vh"
module smrs_regfile (
  // clock and reset
  input wire clk_i,
  input wire rst_i,
  input wire ce_i,
  // access port
  input wire we_i,
  input wire [7:0] waddr_i,
  input wire [7:0] wdata_i,
  input wire [7:0] raddr_i,
  output reg [7:0] rdata_o,
  // register contents
  output reg [7:0] rate_o,
  output reg [7:0] g0_lo_o,
  output reg [7:0] g0_hi_o,
  output reg [7:0] g1_lo_o,
  output reg [7:0] g1_hi_o,
  output reg [7:0] tol_o
);

  reg [7:0] rd_nxt;

  // read mux; unmapped offsets read as zero
  always @*
  begin
    case (raddr_i)
      `SMRS_OFS_RATE: rd_nxt = rate_o;
      `SMRS_OFS_G0_LO: rd_nxt = g0_lo_o;
      `SMRS_OFS_G0_HI: rd_nxt = g0_hi_o;
      `SMRS_OFS_G1_LO: rd_nxt = g1_lo_o;
      `SMRS_OFS_G1_HI: rd_nxt = g1_hi_o;
      `SMRS_OFS_TOL: rd_nxt = tol_o;
      default: rd_nxt = 8'h00;
    endcase
  end

  // storage; writes to unmapped offsets are dropped
  always @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      rdata_o <= `SMRS_REG_RESET;
      rate_o <= `SMRS_REG_RESET;
      g0_lo_o <= `SMRS_REG_RESET;
      g0_hi_o <= `SMRS_REG_RESET;
      g1_lo_o <= `SMRS_REG_RESET;
      g1_hi_o <= `SMRS_REG_RESET;
      tol_o <= `SMRS_REG_RESET;
    end
    else if (ce_i)
    begin
      rdata_o <= rd_nxt;
      if (we_i)
      begin
        case (waddr_i)
          `SMRS_OFS_RATE: rate_o <= wdata_i;
          `SMRS_OFS_G0_LO: g0_lo_o <= wdata_i;
          `SMRS_OFS_G0_HI: g0_hi_o <= wdata_i;
          `SMRS_OFS_G1_LO: g1_lo_o <= wdata_i;
          `SMRS_OFS_G1_HI: g1_hi_o <= wdata_i;
          `SMRS_OFS_TOL: tol_o <= wdata_i;
          default: rate_o <= rate_o;
        endcase
      end
    end
  end

endmodule
`default_nettype wire

// ### smrs_top.v
// two-wire slave port with strap address capture, rate select and lock check
`timescale 1ns/10ps
`default_nettype none
`include "smrs_map.vh"
module smrs_top (
  // clock, reset, enable
  input wire clk_i,
  input wire rst_i,
  input wire ce_i,
  // two-wire bus, open drain
  input wire serial_clock_line_i,
  output reg serial_clock_line_o,
  output reg serial_clock_line_oe_o,
  input wire sda_i,
  output reg sda_o,
  output reg sda_oe_o,
  // power-up straps
  input wire [3:0] address_strap_lines_i,
  input wire bus_role_select_i,
  // lock measurement from the recovery loop
  input wire lock_fail_i,
  input wire [14:0] meas_count_i,
  input wire meas_valid_i,
  // status
  output reg [6:0] bus_addr_o,
  output reg addr_valid_o,
  output reg [3:0] div_allowed_o,
  output reg [3:0] div_sel_o,
  output reg freq_group_o,
  output reg [2:0] vco_set_o,
  output reg freq_lock_o
);

  // one-hot protocol states
  localparam [8:0] ST_IDLE = 9'h001;
  localparam [8:0] ST_ADDR = 9'h002;
  localparam [8:0] ST_AACK = 9'h004;
  localparam [8:0] ST_REG = 9'h008;
  localparam [8:0] ST_RACK = 9'h010;
  localparam [8:0] ST_WR = 9'h020;
  localparam [8:0] ST_WACK = 9'h040;
  localparam [8:0] ST_RD = 9'h080;
  localparam [8:0] ST_MACK = 9'h100;

  reg [2:0] scl_sync_r;
  reg [2:0] sda_sync_r;
  reg [3:0] strap_s1_r;
  reg [3:0] strap_s2_r;
  reg role_s1_r;
  reg role_s2_r;
  reg [1:0] cap_cnt_r;
  reg [8:0] st_r;
  reg [3:0] bit_cnt_r;
  reg [7:0] sh_r;
  reg [7:0] rsh_r;
  reg [7:0] ptr_r;
  reg rw_r;
  reg mnack_r;
  reg we_r;
  reg [7:0] wdata_r;
  reg [3:0] last_nib_r;
  wire scl_rise;
  wire scl_fall;
  wire start_det;
  wire stop_det;
  wire [7:0] rdata;
  wire [7:0] rate;
  wire [7:0] g0_lo;
  wire [7:0] g0_hi;
  wire [7:0] g1_lo;
  wire [7:0] g1_hi;
  wire [7:0] tol;
  wire [3:0] nib;
  reg [3:0] mask0;
  reg [3:0] mask1;
  reg [2:0] vco_nxt;
  wire [3:0] mask_cur;
  wire [14:0] exp_cnt;
  wire manual;
  wire [3:0] tol_cur;
  wire [14:0] diff;

  // the next permitted divider above the current one, wrapping to the lowest
  function [3:0] next_div;
    input [3:0] m;
    input [3:0] c;
    reg [3:0] above;
    begin
      above = m & ~(c | (c - 4'h1));
      if (above != 4'h0)
        next_div = above & (~above + 4'h1);
      else
        next_div = m & (~m + 4'h1);
    end
  endfunction

  // pin synchronisers; stage 0 is only read by stage 1
  always @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      scl_sync_r <= 3'h7;
      sda_sync_r <= 3'h7;
      strap_s1_r <= 4'h0;
      strap_s2_r <= 4'h0;
      role_s1_r <= 1'b0;
      role_s2_r <= 1'b0;
    end
    else if (ce_i)
    begin
      scl_sync_r <= {scl_sync_r[1:0], serial_clock_line_i};
      sda_sync_r <= {sda_sync_r[1:0], sda_i};
      strap_s1_r <= address_strap_lines_i;
      strap_s2_r <= strap_s1_r;
      role_s1_r <= bus_role_select_i;
      role_s2_r <= role_s1_r;
    end
  end

  // bus events seen on the synchronised copies
  assign scl_rise = scl_sync_r[1] & ~scl_sync_r[2];
  assign scl_fall = ~scl_sync_r[1] & scl_sync_r[2];
  assign start_det = scl_sync_r[1] & scl_sync_r[2] & ~sda_sync_r[1] & sda_sync_r[2];
  assign stop_det = scl_sync_r[1] & scl_sync_r[2] & sda_sync_r[1] & ~sda_sync_r[2];

  // address capture once after reset release, after the straps cleared the synchroniser;
  // later strap changes are ignored until the next reset
  always @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      cap_cnt_r <= 2'h0;
      addr_valid_o <= 1'b0;
      bus_addr_o <= `SMRS_ADDR_TEST;
    end
    else if (ce_i && !addr_valid_o)
    begin
      if (cap_cnt_r == `SMRS_CAP_WAIT)
      begin
        addr_valid_o <= 1'b1;
        if (role_s2_r)
          bus_addr_o <= `SMRS_ADDR_TEST;
        else
          bus_addr_o <= `SMRS_ADDR_BASE + {3'h0, strap_s2_r};
      end
      else
        cap_cnt_r <= cap_cnt_r + 2'h1;
    end
  end

  // protocol engine: shifts on clock rise, changes the data line on clock fall
  always @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      st_r <= ST_IDLE;
      bit_cnt_r <= 4'h0;
      sh_r <= 8'h00;
      rsh_r <= 8'h00;
      ptr_r <= 8'h00;
      rw_r <= 1'b0;
      mnack_r <= 1'b0;
      we_r <= 1'b0;
      wdata_r <= 8'h00;
      sda_oe_o <= 1'b0;
    end
    else if (ce_i)
    begin
      we_r <= 1'b0;
      if (!addr_valid_o)
        st_r <= ST_IDLE;
      else if (start_det)
      begin
        st_r <= ST_ADDR;
        bit_cnt_r <= 4'h0;
        sda_oe_o <= 1'b0;
      end
      else if (stop_det)
      begin
        st_r <= ST_IDLE;
        sda_oe_o <= 1'b0;
      end
      else if (scl_rise)
      begin
        case (st_r)
          ST_ADDR, ST_REG, ST_WR:
          begin
            sh_r <= {sh_r[6:0], sda_sync_r[1]};
            bit_cnt_r <= bit_cnt_r + 4'h1;
          end
          ST_RD:
          begin
            rsh_r <= {rsh_r[6:0], 1'b0};
            bit_cnt_r <= bit_cnt_r + 4'h1;
          end
          ST_MACK:
          begin
            mnack_r <= sda_sync_r[1];
            if (!sda_sync_r[1])
              ptr_r <= ptr_r + 8'h01; // next byte readable before the fall
          end
          default: st_r <= st_r;
        endcase
      end
      else if (scl_fall)
      begin
        case (st_r)
          ST_ADDR:
          begin
            if (bit_cnt_r == `SMRS_BITS_BYTE)
            begin
              if (sh_r[7:1] == bus_addr_o)
              begin
                st_r <= ST_AACK;
                rw_r <= sh_r[0];
                sda_oe_o <= 1'b1;
              end
              else
                st_r <= ST_IDLE;
            end
          end
          ST_AACK:
          begin
            bit_cnt_r <= 4'h0;
            if (rw_r)
            begin
              st_r <= ST_RD;
              rsh_r <= rdata;
              sda_oe_o <= ~rdata[7];
            end
            else
            begin
              st_r <= ST_REG;
              sda_oe_o <= 1'b0;
            end
          end
          ST_REG:
          begin
            if (bit_cnt_r == `SMRS_BITS_BYTE)
            begin
              ptr_r <= sh_r;
              st_r <= ST_RACK;
              sda_oe_o <= 1'b1;
            end
          end
          ST_RACK:
          begin
            st_r <= ST_WR;
            bit_cnt_r <= 4'h0;
            sda_oe_o <= 1'b0;
          end
          ST_WR:
          begin
            if (bit_cnt_r == `SMRS_BITS_BYTE)
            begin
              we_r <= 1'b1;
              wdata_r <= sh_r;
              st_r <= ST_WACK;
              sda_oe_o <= 1'b1;
            end
          end
          ST_WACK:
          begin
            ptr_r <= ptr_r + 8'h01;
            st_r <= ST_WR;
            bit_cnt_r <= 4'h0;
            sda_oe_o <= 1'b0;
          end
          ST_RD:
          begin
            if (bit_cnt_r == `SMRS_BITS_BYTE)
            begin
              st_r <= ST_MACK;
              sda_oe_o <= 1'b0;
            end
            else
              sda_oe_o <= ~rsh_r[7];
          end
          ST_MACK:
          begin
            bit_cnt_r <= 4'h0;
            if (mnack_r)
              st_r <= ST_IDLE;
            else
            begin
              st_r <= ST_RD;
              rsh_r <= rdata;
              sda_oe_o <= ~rdata[7];
            end
          end
          ST_IDLE: st_r <= ST_IDLE;
          default: st_r <= ST_IDLE;
        endcase
      end
    end
  end

  // the pins only ever pull low; clock is never stretched
  always @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      sda_o <= 1'b0;
      serial_clock_line_o <= 1'b0;
      serial_clock_line_oe_o <= 1'b0;
    end
    else if (ce_i)
    begin
      sda_o <= 1'b0;
      serial_clock_line_o <= 1'b0;
      serial_clock_line_oe_o <= 1'b0;
    end
  end

  smrs_regfile u_regs (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .we_i(we_r),
    .waddr_i(ptr_r),
    .wdata_i(wdata_r),
    .raddr_i(ptr_r),
    .rdata_o(rdata),
    .rate_o(rate),
    .g0_lo_o(g0_lo),
    .g0_hi_o(g0_hi),
    .g1_lo_o(g1_lo),
    .g1_hi_o(g1_hi),
    .tol_o(tol)
  );

  assign nib = rate[7:4];

  // rate nibble to divider sets per group and coarse tuning preset
  always @*
  begin
    case (nib)
      `SMRS_RATE_IB:
      begin
        mask0 = `SMRS_DIV_124;
        mask1 = `SMRS_DIV_124;
        vco_nxt = `SMRS_VCO_10G0;
      end
      `SMRS_RATE_CPRI1:
      begin
        mask0 = `SMRS_DIV_124;
        mask1 = `SMRS_DIV_124;
        vco_nxt = `SMRS_VCO_9G8304;
      end
      `SMRS_RATE_CPRI2:
      begin
        mask0 = `SMRS_DIV_24;
        mask1 = `SMRS_DIV_24;
        vco_nxt = `SMRS_VCO_12G288;
      end
      `SMRS_RATE_PROP3:
      begin
        mask0 = `SMRS_DIV_2;
        mask1 = `SMRS_DIV_2;
        vco_nxt = `SMRS_VCO_12G5;
      end
      `SMRS_RATE_ILK1:
      begin
        mask0 = `SMRS_DIV_24;
        mask1 = `SMRS_DIV_24;
        vco_nxt = `SMRS_VCO_12G5;
      end
      `SMRS_RATE_ILK2:
      begin
        mask0 = `SMRS_DIV_1;
        mask1 = `SMRS_DIV_1;
        vco_nxt = `SMRS_VCO_10G3125;
      end
      `SMRS_RATE_ETH:
      begin
        mask0 = `SMRS_DIV_8;
        mask1 = `SMRS_DIV_1;
        vco_nxt = freq_group_o ? `SMRS_VCO_10G3125 : `SMRS_VCO_10G0;
      end
      default:
      begin
        mask0 = `SMRS_DIV_ANY; // unrestricted
        mask1 = `SMRS_DIV_ANY;
        vco_nxt = `SMRS_VCO_FREE;
      end
    endcase
  end

  assign mask_cur = freq_group_o ? mask1 : mask0;

  // divider and group stepping: a new rate code restarts at the lowest ratio,
  // each failed lock attempt moves on without software help
  always @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      last_nib_r <= 4'h0;
      freq_group_o <= 1'b0;
      div_sel_o <= `SMRS_DIV_1;
      div_allowed_o <= `SMRS_DIV_ANY;
      vco_set_o <= `SMRS_VCO_FREE;
    end
    else if (ce_i)
    begin
      last_nib_r <= nib;
      div_allowed_o <= mask_cur;
      vco_set_o <= vco_nxt;
      if (nib != last_nib_r)
      begin
        freq_group_o <= 1'b0;
        div_sel_o <= mask0 & (~mask0 + 4'h1);
      end
      else if (lock_fail_i)
      begin
        if (nib == `SMRS_RATE_ETH)
        begin
          freq_group_o <= ~freq_group_o;
          div_sel_o <= freq_group_o ? mask0 : mask1;
        end
        else
          div_sel_o <= next_div(mask_cur, div_sel_o);
      end
    end
  end

  // expected count and tolerance of the active group
  assign exp_cnt = freq_group_o ? {g1_hi[6:0], g1_lo} : {g0_hi[6:0], g0_lo};
  assign manual = freq_group_o ? g1_hi[`SMRS_HI_MANUAL] : g0_hi[`SMRS_HI_MANUAL];
  assign tol_cur = freq_group_o ? tol[`SMRS_TOL_G1_LSB+3:`SMRS_TOL_G1_LSB]
                                : tol[`SMRS_TOL_G0_LSB+3:`SMRS_TOL_G0_LSB];
  assign diff = (meas_count_i >= exp_cnt) ? (meas_count_i - exp_cnt)
                                          : (exp_cnt - meas_count_i);

  // lock verdict per measurement; without a manual count no lock is declared,
  // which keeps a stale reset value from passing a false lock
  always @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      freq_lock_o <= 1'b0;
    else if (ce_i)
    begin
      if (lock_fail_i)
        freq_lock_o <= 1'b0;
      else if (meas_valid_i)
        freq_lock_o <= manual && (diff <= {11'h000, tol_cur});
    end
  end

endmodule
`default_nettype wire

// ### smrs_top_properties.sv
// assertions on the two-wire slave port, address capture and rate outputs
`timescale 1ns/10ps
`default_nettype none
module smrs_top_properties (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // bus pins and straps
  input wire logic serial_clock_line_i,
  input wire logic serial_clock_line_oe_o,
  input wire logic sda_o,
  input wire logic sda_oe_o,
  input wire logic [3:0] address_strap_lines_i,
  input wire logic bus_role_select_i,
  // lock inputs and status
  input wire logic lock_fail_i,
  input wire logic meas_valid_i,
  input wire logic [6:0] bus_addr_o,
  input wire logic addr_valid_o,
  input wire logic [3:0] div_allowed_o,
  input wire logic [3:0] div_sel_o,
  input wire logic [2:0] vco_set_o,
  input wire logic freq_lock_o
);
  // one clock domain, so clock and disable are given once
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  // pins are only ever pulled low or released
  AST_SCL_RELEASED: assert property (!serial_clock_line_oe_o)
    else $error("clock line enabled");
  AST_SDA_LOW_ONLY: assert property (sda_oe_o |-> !sda_o)
    else $error("data line driven high");
  // captured address follows the straps, or the fixed test address
  AST_ADDR_STRAP: assert property ($rose(addr_valid_o) && !bus_role_select_i
    |-> ##1 bus_addr_o == 7'h18 + {3'h0, address_strap_lines_i}) else $error("strap address");
  AST_ADDR_TEST: assert property ($rose(addr_valid_o) && bus_role_select_i
    |-> ##1 bus_addr_o == 7'h18) else $error("test address");
  AST_ADDR_HELD: assert property (addr_valid_o |=> addr_valid_o && $stable(bus_addr_o))
    else $error("address changed");
  // capture completes a fixed few cycles after release
  AST_VALID_TIMING: assert property ($fell(rst_i) |-> !addr_valid_o [*4] ##[1:3] addr_valid_o)
    else $error("capture timing");
  // the running divider is always one-hot, a single ratio
  AST_DIV_ONEHOT: assert property ($onehot(div_sel_o))
    else $error("divider not one-hot");
  AST_PRESET_10G3: assert property (vco_set_o == 3'h5 |-> div_allowed_o == 4'h1)
    else $error("10.3125 preset dividers");
  AST_LOCK_CLEAR: assert property (lock_fail_i && !meas_valid_i |=> !freq_lock_o)
    else $error("lock kept after failure");
  // ack and read bits move only while the bus clock is low
  AST_ACK_ON_LOW: assert property ($changed(sda_oe_o) |-> !serial_clock_line_i)
    else $error("data moved with clock high");

  CVR_CAPTURE: cover property ($rose(addr_valid_o));
  CVR_GROUP1: cover property (vco_set_o == 3'h5 && div_sel_o == 4'h1);
  CVR_LOCK: cover property ($rose(freq_lock_o));
endmodule
bind smrs_top smrs_top_properties u_props (.clk_i, .rst_i, .serial_clock_line_i,
  .serial_clock_line_oe_o, .sda_o, .sda_oe_o, .address_strap_lines_i, .bus_role_select_i,
  .lock_fail_i, .meas_valid_i, .bus_addr_o, .addr_valid_o, .div_allowed_o, .div_sel_o,
  .vco_set_o, .freq_lock_o);
`default_nettype wire

// ### smrs_master_model.sv
// two-wire bus master model standing in for the system controller
`timescale 1ns/10ps
`default_nettype none
module smrs_master_model (
  // clock and bus
  input wire logic clk_i,
  input wire logic sda_i,
  output logic scl_low_o,
  output logic sda_low_o
);
  // lines released and the bus clock standing high outside frames
  initial
  begin
    scl_low_o = 1'b0;
    sda_low_o = 1'b0;
  end
  task automatic clks(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  // start or repeated start; waits for a held ack to be let go first
  task automatic start;
    sda_low_o <= 1'b0;
    clks(4);
    scl_low_o <= 1'b0;
    clks(4);
    sda_low_o <= 1'b1;
    clks(4);
    scl_low_o <= 1'b1;
  endtask
  task automatic stop;
    clks(2);
    sda_low_o <= 1'b1;
    clks(4);
    scl_low_o <= 1'b0;
    clks(4);
    sda_low_o <= 1'b0;
    clks(4);
  endtask
  // one 200 ns bus clock: data set mid-low, sampled at the end of high
  task automatic bit_xfer(input logic b, output logic r);
    clks(2);
    sda_low_o <= ~b;
    clks(2);
    scl_low_o <= 1'b0;
    clks(4);
    r = sda_i;
    scl_low_o <= 1'b1;
  endtask
  // eight bits msb first, then the ninth bit; last=1 releases it
  task automatic byte_xfer(input logic [7:0] d, input logic last, output logic [7:0] q,
    output logic ack);
    logic a;
    for (int i = 7; i >= 0; i--)
      bit_xfer(d[i], q[i]);
    bit_xfer(last, a);
    ack = ~a;
  endtask
  task automatic wr(input logic [6:0] a7, input logic [7:0] ofs, input logic [7:0] d,
    output logic ack);
    logic [7:0] q;
    logic k0, k1, k2;
    start();
    byte_xfer({a7, 1'b0}, 1'b1, q, k0);
    byte_xfer(ofs, 1'b1, q, k1);
    byte_xfer(d, 1'b1, q, k2);
    stop();
    ack = k0 & k1 & k2;
  endtask
  // single-byte read ends with a nack so the slave lets go
  task automatic rd(input logic [6:0] a7, input logic [7:0] ofs, output logic [7:0] d,
    output logic ack);
    logic [7:0] q;
    logic k0, k1, k2, k3;
    start();
    byte_xfer({a7, 1'b0}, 1'b1, q, k0);
    byte_xfer(ofs, 1'b1, q, k1);
    start();
    byte_xfer({a7, 1'b1}, 1'b1, q, k2);
    byte_xfer(8'hff, 1'b1, d, k3);
    stop();
    ack = k0 & k1 & k2;
  endtask
endmodule
`default_nettype wire

// ### smrs_top_bench.sv
// self-checking bench for the two-wire slave port and rate selection
`timescale 1ns/10ps
`default_nettype none
`include "smrs_map.vh"
module smrs_top_bench;
  // stimulus, observed outputs and tables
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic fail_p = 1'b0;
  logic mvalid = 1'b0;
  logic [14:0] mcount = 15'h0;
  logic [3:0] straps = 4'h5;
  logic role = 1'b0;
  logic [6:0] a7 = 7'h1d;
  logic k;
  wire logic scl_low, sda_low, scl_o, scl_oe, sda_o, sda_oe, valid, grp, lock;
  wire logic [6:0] addr;
  wire logic [3:0] dal, dsel;
  wire logic [2:0] vco;
  int failures = 0;
  int n_compared = 0;
  logic [7:0] rate_t [6] = '{8'h26, 8'h36, 8'h46, 8'ha6, 8'hb6, 8'hc6};
  // {group, preset, allowed dividers, first divider}
  logic [11:0] exp_t [6] = '{12'h171, 12'h271, 12'h362, 12'h422, 12'h462, 12'h511};
  // 10.0 x 1280 = 0x3200 and 10.3125 x 1280 = 0x3390, manual bit set
  logic [7:0] cnt_t [5] = '{8'h00, 8'hb2, 8'h90, 8'hb3, 8'hf3};
  logic [14:0] meas_t [4] = '{15'h3203, 15'h3204, 15'h31fd, 15'h31fd};
  logic [3:0] lock_t = 4'h5;
  // open-drain wires with pull-ups: low while anybody pulls
  wire logic scl_w = ~(scl_low | (scl_oe & ~scl_o));
  wire logic sda_w = ~(sda_low | (sda_oe & ~sda_o));

  always #12.5 clk_i = ~clk_i;

  smrs_top DUT (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .serial_clock_line_i(scl_w),
    .serial_clock_line_o(scl_o), .serial_clock_line_oe_o(scl_oe), .sda_i(sda_w), .sda_o(sda_o),
    .sda_oe_o(sda_oe), .address_strap_lines_i(straps), .bus_role_select_i(role),
    .lock_fail_i(fail_p), .meas_count_i(mcount), .meas_valid_i(mvalid), .bus_addr_o(addr),
    .addr_valid_o(valid), .div_allowed_o(dal), .div_sel_o(dsel), .freq_group_o(grp),
    .vco_set_o(vco), .freq_lock_o(lock));
  smrs_master_model bm (.clk_i(clk_i), .sda_i(sda_w), .scl_low_o(scl_low), .sda_low_o(sda_low));

  task automatic check(input string what, input logic [15:0] e, input logic [15:0] g);
    n_compared++;
    if (g !== e)
    begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic tally_and_finish;
    $display("compared %0d mismatched %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // straps stay put until well after capture
  task automatic power_up(input logic [3:0] s, input logic r);
    straps <= s;
    role <= r;
    rst_i <= 1'b1;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (8) @(posedge clk_i);
  endtask
  task automatic wreg(input logic [7:0] ofs, input logic [7:0] d);
    bm.wr(a7, ofs, d, k);
    check("write ack", 1'b1, k);
  endtask
  task automatic rreg(input logic [7:0] ofs, input logic [7:0] e);
    logic [7:0] d;
    bm.rd(a7, ofs, d, k);
    check("read ack", 1'b1, k);
    check("read data", e, d);
  endtask
  // one-cycle failure or measurement pulse, then time for the result
  task automatic pulse(input logic f, input logic [14:0] c);
    fail_p <= f;
    mvalid <= ~f;
    mcount <= c;
    @(posedge clk_i);
    fail_p <= 1'b0;
    mvalid <= 1'b0;
    repeat (4) @(posedge clk_i);
  endtask

  initial
  begin
    power_up(4'h5, 1'b0);
    check("address", 8'h9d, {valid, addr});
    straps <= 4'ha;
    bm.wr(7'h18, `SMRS_OFS_RATE, 8'h26, k);
    check("foreign ack", 1'b0, k);
    check("address kept", 7'h1d, addr);
    for (int i = 0; i < 6; i++)
    begin
      wreg(`SMRS_OFS_RATE, rate_t[i]);
      rreg(`SMRS_OFS_RATE, rate_t[i]);
      check("rate outputs", exp_t[i], {grp, vco, dal, dsel});
    end
    wreg(`SMRS_OFS_RATE, 8'hf6);
    check("group 0 outputs", 12'h188, {grp, vco, dal, dsel});
    pulse(1'b1, 15'h0);
    check("group 1 outputs", 12'hd11, {grp, vco, dal, dsel});
    wreg(`SMRS_OFS_RATE, 8'h26);
    for (int i = 0; i < 3; i++)
    begin
      pulse(1'b1, 15'h0);
      check("divider step", (i == 2) ? 4'h1 : 4'h2 << i, dsel);
    end
    for (int i = 0; i < 5; i++)
    begin
      wreg(8'(`SMRS_OFS_G0_LO + i), cnt_t[i]);
      rreg(8'(`SMRS_OFS_G0_LO + i), cnt_t[i]);
    end
    // low tolerance nibble of 3 belongs to group 0
    for (int i = 0; i < 4; i++)
    begin
      pulse(i == 3, meas_t[i]);
      check("lock", lock_t[i], lock);
    end
    wreg(`SMRS_OFS_TOL, 8'h3f);
    pulse(1'b0, 15'h320c);
    check("lock wide", 1'b1, lock);
    wreg(`SMRS_OFS_G0_HI, 8'h32);
    pulse(1'b0, 15'h3200);
    check("lock unloaded", 1'b0, lock);
    wreg(8'h10, 8'h5a);
    rreg(8'h10, 8'h00);
    power_up(4'hf, 1'b1);
    check("test address", 8'h98, {valid, addr});
    // a cleared rate register leaves tuning free and every divider permitted
    check("free rate outputs", 12'h0f1, {grp, vco, dal, dsel});
    bm.wr(7'h27, `SMRS_OFS_RATE, 8'h26, k);
    check("strap ack", 1'b0, k);
    a7 = 7'h18;
    rreg(`SMRS_OFS_RATE, 8'h00);
    tally_and_finish();
  end

  // about 8700 cycles of traffic; a hang stops here
  initial
  begin
    repeat (60000) @(posedge clk_i);
    failures++;
    $display("MISMATCH run time expected end seen timeout");
    tally_and_finish();
  end
endmodule
`default_nettype wire
